// ### inc/fault_mgr_pkg.sv
// shared types of the fault manager
package fault_mgr_pkg;
  typedef enum logic [1:0] {
    CAT_NONE,
    CAT_AUTO,
    CAT_HARD
  } fault_cat_e;
  typedef logic [7:0] fault_code_t;
endpackage

// ### inc/fault_mgr_regs.svh
// register offsets, field positions, reset values and timing counts of the fault manager
`ifndef FAULT_MGR_REGS_SVH
`define FAULT_MGR_REGS_SVH
`define FM_OFS_CTRL        8'h00
`define FM_OFS_STATUS      8'h04
`define FM_OFS_TRIES       8'h08
`define FM_OFS_DELAY       8'h0C
`define FM_OFS_CLEAR       8'h10
`define FM_OFS_STOPSEL     8'h14
`define FM_OFS_DIN1_FN     8'h18
`define FM_OFS_DIN2_FN     8'h1C
`define FM_OFS_HIST0       8'h20
`define FM_OFS_HIST1       8'h24
`define FM_OFS_HIST2       8'h28
`define FM_OFS_IRQ_STAT    8'h2C
`define FM_OFS_IRQ_MASK    8'h30
`define FM_CLR_IDLE        2'h0
`define FM_CLR_RESET       2'h1
`define FM_CLR_BUFFER      2'h2
`define FM_STOPSEL_MAX     4'h3
`define FM_DIN_FN_CLEAR    8'h07
`define FM_CODE_OVERVOLT   8'h05
`define FM_CODE_UNDERVOLT  8'h04
`define FM_CODE_HEATSINK   8'h08
`define FM_IRQ_FAULT       0
`define FM_IRQ_CLEARED     1
`define FM_IRQ_RESTART     2
`define FM_IRQ_GIVEUP      3
`define FM_CLK_HZ          200000000
`define FM_TICK_MS         1
`define FM_TICK_CYCLES     ((`FM_CLK_HZ / 1000) * `FM_TICK_MS)
`define FM_BLINK_TICKS     16'h01F4
`define FM_TRIES_RST       8'h00
`define FM_DELAY_RST       16'h0000
`endif

// ### inc/fault_tick_if.sv
// tick and countdown signals between the manager and its timer
`timescale 1ns/1ps
interface fault_tick_if;
  logic        load;
  logic [15:0] load_val;
  logic        run;
  logic        tick;
  logic        expired;
  modport mgr   (output load, output load_val, output run, input tick, input expired);
  modport timer (input load, input load_val, input run, output tick, output expired);
endinterface

// ### rtl/drive_fault_manager.sv
// fault manager: latch, classify, clear and auto-restart, with avalon-mm registers
`timescale 1ns/1ps
`include "fault_mgr_regs.svh"
module drive_fault_manager #(
  parameter int TICK_CYCLES = `FM_TICK_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_fault_raise,
  input  wire logic [7:0]  i_fault_code,
  input  wire logic        i_fault_hard,
  input  wire logic        i_fault_present,
  input  wire logic        i_key_stop,
  input  wire logic        i_key_esc,
  input  wire logic [1:0]  i_din,
  input  wire logic [7:0]  i_avm_address,
  input  wire logic        i_avm_read,
  input  wire logic        i_avm_write,
  input  wire logic [31:0] i_avm_writedata,
  output logic [31:0]      o_avm_readdata,
  output logic             o_avm_waitrequest,
  output logic             o_drive_enable,
  output logic             o_start_request,
  output logic             o_disp_fault_on,
  output logic [7:0]       o_disp_fault_num,
  output logic             o_keypad_owned,
  output logic             o_irq
);
  typedef enum logic [2:0] {
    ST_RUN,
    ST_FAULT,
    ST_WAIT,
    ST_TRY,
    ST_HOLD
  } mgr_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0]  restart_attempt_count_q;
  logic [15:0] restart_delay_setting_q;
  logic [3:0]  stop_behaviour_select_q;
  logic [7:0]  digital_input1_function_q;
  logic [7:0]  digital_input2_function_q;
  logic [3:0]  irq_mask_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_evt;
  logic        run_cmd_q;
  logic        wr_q;
  logic        rd_q;
  logic [1:0]  clear_req_q;

  // one wait state so reads come from a registered mux
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= i_avm_write && o_avm_waitrequest && !wr_q;
      rd_q <= i_avm_read && o_avm_waitrequest && !rd_q;
    end
  end

  logic wr_go;
  assign wr_go = i_avm_write && wr_q;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      restart_attempt_count_q   <= `FM_TRIES_RST;
      restart_delay_setting_q   <= `FM_DELAY_RST;
      stop_behaviour_select_q   <= 4'h0;
      digital_input1_function_q <= 8'h00;
      digital_input2_function_q <= 8'h00;
      irq_mask_q                <= 4'h0;
      run_cmd_q                 <= 1'b0;
    end else if (wr_go) begin
      if (i_avm_address == `FM_OFS_CTRL) begin
        run_cmd_q <= i_avm_writedata[0];
      end else if (i_avm_address == `FM_OFS_TRIES) begin
        restart_attempt_count_q <= i_avm_writedata[7:0];
      end else if (i_avm_address == `FM_OFS_DELAY) begin
        restart_delay_setting_q <= i_avm_writedata[15:0];
      end else if (i_avm_address == `FM_OFS_STOPSEL) begin
        stop_behaviour_select_q <= i_avm_writedata[3:0];
      end else if (i_avm_address == `FM_OFS_DIN1_FN) begin
        digital_input1_function_q <= i_avm_writedata[7:0];
      end else if (i_avm_address == `FM_OFS_DIN2_FN) begin
        digital_input2_function_q <= i_avm_writedata[7:0];
      end else if (i_avm_address == `FM_OFS_IRQ_MASK) begin
        irq_mask_q <= i_avm_writedata[3:0];
      end
    end
  end

  // clear request decoded as a one-cycle command; register reads back idle
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      clear_req_q <= `FM_CLR_IDLE;
    end else if (wr_go && i_avm_address == `FM_OFS_CLEAR) begin
      clear_req_q <= i_avm_writedata[1:0];
    end else begin
      clear_req_q <= `FM_CLR_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // manual clear sources
  logic [1:0] din_q;
  logic [1:0] din_toggle;
  logic       stop_q;
  logic       manual_clear;
  logic       stop_ok;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      din_q  <= 2'b00;
      stop_q <= 1'b0;
    end else begin
      din_q  <= i_din;
      stop_q <= i_key_stop;
    end
  end

  assign din_toggle[0] = (i_din[0] != din_q[0])
                         && digital_input1_function_q == `FM_DIN_FN_CLEAR;
  assign din_toggle[1] = (i_din[1] != din_q[1])
                         && digital_input2_function_q == `FM_DIN_FN_CLEAR;
  assign stop_ok = stop_behaviour_select_q <= `FM_STOPSEL_MAX;
  assign manual_clear = (i_key_stop && !stop_q && stop_ok)
                        || clear_req_q == `FM_CLR_RESET
                        || clear_req_q == `FM_CLR_BUFFER
                        || (|din_toggle);

  ////////////////////////////////////////////////////////////////////////////////
  // fault state machine
  mgr_state_e               state_q;
  fault_mgr_pkg::fault_cat_e cat_q;
  fault_mgr_pkg::fault_code_t code_q;
  logic [7:0]               tries_used_q;
  logic                     ack_q;
  logic                     blink_q;
  logic [15:0]              blink_cnt_q;
  logic                     volt_heat;
  logic                     clear_ok;
  logic                     auto_ok;
  fault_tick_if             tif ();

  assign volt_heat = code_q == `FM_CODE_OVERVOLT || code_q == `FM_CODE_UNDERVOLT
                     || code_q == `FM_CODE_HEATSINK;
  assign clear_ok  = !i_fault_present;
  assign auto_ok   = cat_q == fault_mgr_pkg::CAT_AUTO
                     && (restart_delay_setting_q != 16'h0000 || volt_heat);

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q      <= ST_RUN;
      cat_q        <= fault_mgr_pkg::CAT_NONE;
      code_q       <= 8'h00;
      tries_used_q <= 8'h00;
    end else if (i_fault_raise && state_q == ST_RUN) begin
      state_q      <= ST_FAULT;
      code_q       <= i_fault_code;
      cat_q        <= i_fault_hard ? fault_mgr_pkg::CAT_HARD : fault_mgr_pkg::CAT_AUTO;
      tries_used_q <= 8'h00;
    end else begin
      case (state_q)
        ST_RUN: begin
        end
        ST_FAULT: begin
          if (manual_clear && clear_ok) begin
            state_q <= ST_RUN;
            cat_q   <= fault_mgr_pkg::CAT_NONE;
          end else if (cat_q == fault_mgr_pkg::CAT_AUTO
                       && restart_attempt_count_q != 8'h00) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (manual_clear && clear_ok) begin
            state_q <= ST_RUN;
            cat_q   <= fault_mgr_pkg::CAT_NONE;
          end else if (tif.expired) begin
            state_q <= ST_TRY;
          end
        end
        ST_TRY: begin
          tries_used_q <= tries_used_q + 8'h01;
          if (clear_ok && auto_ok) begin
            state_q <= ST_RUN;
            cat_q   <= fault_mgr_pkg::CAT_NONE;
          end else if (tries_used_q + 8'h01 >= restart_attempt_count_q) begin
            state_q <= ST_HOLD;
          end else begin
            state_q <= ST_WAIT;
          end
        end
        ST_HOLD: begin
          if (manual_clear && clear_ok) begin
            state_q <= ST_RUN;
            cat_q   <= fault_mgr_pkg::CAT_NONE;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  logic entering_wait;
  logic auto_clear_ev;
  logic restart_ev;
  assign entering_wait = (state_q == ST_FAULT || state_q == ST_TRY)
                         && !(manual_clear && clear_ok) && !(i_fault_raise && state_q == ST_RUN);
  assign auto_clear_ev = state_q == ST_TRY && clear_ok && auto_ok;
  // restart only when a delay was configured; with zero delay only the supply and heatsink codes clear, in place
  assign restart_ev    = auto_clear_ev && restart_delay_setting_q != 16'h0000;

  assign tif.load     = entering_wait;
  assign tif.load_val = restart_delay_setting_q;
  assign tif.run      = state_q == ST_WAIT;

  fault_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .tif     (tif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // history
  fault_mgr_pkg::fault_code_t hist [3];
  fault_history #(
    .DEPTH (3)
  ) u_hist (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_push  (i_fault_raise && state_q == ST_RUN),
    .i_code  (i_fault_code),
    .i_clear (clear_req_q == `FM_CLR_BUFFER),
    .o_slot  (hist)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // drive outputs and keypad display
  logic faulted;
  assign faulted = state_q != ST_RUN;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_drive_enable  <= 1'b0;
      o_start_request <= 1'b0;
    end else begin
      o_drive_enable  <= run_cmd_q && !faulted && !(i_fault_raise && state_q == ST_RUN);
      o_start_request <= restart_ev;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else if (i_fault_raise && state_q == ST_RUN) begin
      ack_q <= 1'b0;
    end else if (faulted && i_key_esc) begin
      ack_q <= 1'b1;
    end else if (!faulted) begin
      ack_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset || !faulted) begin
      blink_cnt_q <= 16'h0000;
      blink_q     <= 1'b0;
    end else if (tif.tick) begin
      if (blink_cnt_q == `FM_BLINK_TICKS - 16'h0001) begin
        blink_cnt_q <= 16'h0000;
        blink_q     <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_disp_fault_on  <= 1'b0;
      o_disp_fault_num <= 8'h00;
      o_keypad_owned   <= 1'b1;
    end else begin
      o_disp_fault_on  <= faulted && !ack_q && !blink_q;
      o_disp_fault_num <= (faulted && !ack_q && !blink_q) ? code_q : 8'h00;
      o_keypad_owned   <= !faulted || ack_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over write-one-to-clear
  assign irq_evt[`FM_IRQ_FAULT]   = i_fault_raise && state_q == ST_RUN;
  assign irq_evt[`FM_IRQ_CLEARED] = faulted && (auto_clear_ev || (manual_clear && clear_ok
                                    && state_q != ST_TRY));
  assign irq_evt[`FM_IRQ_RESTART] = restart_ev;
  assign irq_evt[`FM_IRQ_GIVEUP]  = state_q == ST_TRY && !(clear_ok && auto_ok)
                                    && tries_used_q + 8'h01 >= restart_attempt_count_q;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_stat_q <= 4'h0;
    end else if (wr_go && i_avm_address == `FM_OFS_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~i_avm_writedata[3:0]) | irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_avm_waitrequest <= 1'b1;
    end else begin
      o_avm_waitrequest <= !((i_avm_read && o_avm_waitrequest && !rd_q)
                             || (i_avm_write && o_avm_waitrequest && !wr_q));
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_avm_readdata <= 32'h0000_0000;
    end else if (i_avm_read && o_avm_waitrequest && !rd_q) begin
      if (i_avm_address == `FM_OFS_CTRL) begin
        o_avm_readdata <= {31'h0, run_cmd_q};
      end else if (i_avm_address == `FM_OFS_STATUS) begin
        o_avm_readdata <= {16'h0, tries_used_q, 2'h0, cat_q, ack_q, state_q};
      end else if (i_avm_address == `FM_OFS_TRIES) begin
        o_avm_readdata <= {24'h0, restart_attempt_count_q};
      end else if (i_avm_address == `FM_OFS_DELAY) begin
        o_avm_readdata <= {16'h0, restart_delay_setting_q};
      end else if (i_avm_address == `FM_OFS_STOPSEL) begin
        o_avm_readdata <= {28'h0, stop_behaviour_select_q};
      end else if (i_avm_address == `FM_OFS_DIN1_FN) begin
        o_avm_readdata <= {24'h0, digital_input1_function_q};
      end else if (i_avm_address == `FM_OFS_DIN2_FN) begin
        o_avm_readdata <= {24'h0, digital_input2_function_q};
      end else if (i_avm_address == `FM_OFS_HIST0) begin
        o_avm_readdata <= {24'h0, hist[0]};
      end else if (i_avm_address == `FM_OFS_HIST1) begin
        o_avm_readdata <= {24'h0, hist[1]};
      end else if (i_avm_address == `FM_OFS_HIST2) begin
        o_avm_readdata <= {24'h0, hist[2]};
      end else if (i_avm_address == `FM_OFS_IRQ_STAT) begin
        o_avm_readdata <= {28'h0, irq_stat_q};
      end else if (i_avm_address == `FM_OFS_IRQ_MASK) begin
        o_avm_readdata <= {28'h0, irq_mask_q};
      end else begin
        o_avm_readdata <= 32'h0000_0000;
      end
    end
  end
endmodule // drive_fault_manager

// ### rtl/fault_history.sv
// three-deep fault code history, newest in slot zero
`timescale 1ns/1ps
module fault_history #(
  parameter int DEPTH = 3
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  input  wire logic                   i_push,
  input  wire fault_mgr_pkg::fault_code_t i_code,
  input  wire logic                   i_clear,
  output fault_mgr_pkg::fault_code_t  o_slot [DEPTH]
);
  fault_mgr_pkg::fault_code_t mem_q [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_slot
      always_ff @(posedge i_mclk) begin
        if (i_reset || i_clear) begin
          mem_q[g] <= 8'h00;
        end else if (i_push) begin
          mem_q[g] <= (g == 0) ? i_code : mem_q[(g == 0) ? 0 : g - 1];
        end
      end
      assign o_slot[g] = mem_q[g];
    end
  endgenerate
endmodule // fault_history

// ### rtl/fault_timer.sv
// millisecond tick divider and restart delay countdown
`timescale 1ns/1ps
`include "fault_mgr_regs.svh"
module fault_timer #(
  parameter int TICK_CYCLES = `FM_TICK_CYCLES
) (
  input  wire logic   i_mclk,
  input  wire logic   i_reset,
  fault_tick_if.timer tif
);
  logic [31:0] div_q;
  logic [15:0] cnt_q;
  logic        tick_q;
  logic        exp_q;

  always_ff @(posedge i_mclk) begin
    if (i_reset || div_q == 32'(TICK_CYCLES - 1)) begin
      div_q  <= 32'h0000_0000;
      tick_q <= !i_reset;
    end else begin
      div_q  <= div_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cnt_q <= 16'h0000;
      exp_q <= 1'b0;
    end else if (tif.load) begin
      cnt_q <= tif.load_val;
      exp_q <= 1'b0;
    end else if (tif.run && cnt_q == 16'h0000) begin
      exp_q <= 1'b1;
    end else if (tif.run && tick_q) begin
      cnt_q <= cnt_q - 16'h0001;
    end else begin
      exp_q <= 1'b0;
    end
  end

  assign tif.tick    = tick_q;
  assign tif.expired = exp_q;
endmodule // fault_timer

// ### sim/drive_fault_manager_properties.sv
// port assertions of the fault manager
`timescale 1ns/1ps
module drive_fault_manager_properties (
  input wire logic       i_mclk,
  input wire logic       i_reset,
  input wire logic       i_fault_raise,
  input wire logic [7:0] i_fault_code,
  input wire logic       i_fault_present,
  input wire logic       i_key_esc,
  input wire logic       i_avm_read,
  input wire logic       i_avm_write,
  input wire logic       o_avm_waitrequest,
  input wire logic       o_drive_enable,
  input wire logic       o_start_request,
  input wire logic [7:0] o_disp_fault_num,
  input wire logic       o_keypad_owned
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic [7:0] code_q;
  always_ff @(posedge i_mclk) begin
    if (i_fault_raise && o_drive_enable)
      code_q <= i_fault_code;
  end
  chk_fault_stops: assert property (
    i_fault_raise && o_drive_enable |=> !o_drive_enable) else $error("drive ran on");
  chk_fault_shown: assert property (
    i_fault_raise && o_drive_enable |-> ##[1:3] o_disp_fault_num == code_q)
    else $error("code not shown");
  chk_start_clean: assert property (
    o_start_request |-> !$past(i_fault_present)) else $error("start with cause");
  chk_start_once: assert property (
    o_start_request |=> !o_start_request) else $error("start too long");
  chk_start_runs: assert property (
    o_start_request |-> ##[0:2] o_drive_enable) else $error("start did not run");
  chk_disp_hidden: assert property (
    o_keypad_owned |-> o_disp_fault_num == 8'h00) else $error("display kept");
  chk_esc_ack: assert property (
    i_key_esc && !o_keypad_owned |-> ##[1:2] o_keypad_owned) else $error("esc ignored");
  chk_cause_holds: assert property (
    i_fault_present && !o_drive_enable |=> !o_drive_enable) else $error("cleared with cause");
  chk_bus_answer: assert property (
    $rose(i_avm_read || i_avm_write) |=> !o_avm_waitrequest) else $error("late answer");
  chk_bus_single: assert property (
    !o_avm_waitrequest |=> o_avm_waitrequest) else $error("answer held");
  cover property (o_start_request);
  cover property (i_key_esc && !o_keypad_owned);
  cover property (i_fault_raise && o_drive_enable);
endmodule // drive_fault_manager_properties
bind drive_fault_manager drive_fault_manager_properties i_chk (.i_mclk, .i_reset,
  .i_fault_raise, .i_fault_code, .i_fault_present, .i_key_esc, .i_avm_read, .i_avm_write,
  .o_avm_waitrequest, .o_drive_enable, .o_start_request, .o_disp_fault_num, .o_keypad_owned);

// ### sim/drive_side_model.sv
// keypad, digital inputs and fault source facing the fault manager
`timescale 1ns/1ps
module drive_side_model (
  input  wire logic i_mclk,
  output logic       o_fault_raise,
  output logic [7:0] o_fault_code,
  output logic       o_fault_hard,
  output logic       o_fault_present,
  output logic       o_key_stop,
  output logic       o_key_esc,
  output logic [1:0] o_din
);
  initial begin
    {o_fault_raise, o_fault_code, o_fault_hard, o_fault_present} = '0;
    {o_key_stop, o_key_esc, o_din} = '0;
  end
  task automatic trip(input logic [7:0] c, input logic h);
    @(posedge i_mclk);
    o_fault_code    <= c;
    o_fault_hard    <= h;
    o_fault_present <= 1'b1;
    o_fault_raise   <= 1'b1;
    @(posedge i_mclk);
    o_fault_raise <= 1'b0;
    // code is meaningless once raise drops
    o_fault_code  <= ~c;
  endtask
  task automatic cure();
    @(posedge i_mclk);
    o_fault_present <= 1'b0;
  endtask
  // k 0 stop, 1 escape; held two cycles
  task automatic press(input int k);
    @(posedge i_mclk);
    o_key_stop <= (k == 0);
    o_key_esc  <= (k == 1);
    repeat (2) @(posedge i_mclk);
    o_key_stop <= 1'b0;
    o_key_esc  <= 1'b0;
  endtask
  task automatic toggle(input int i);
    @(posedge i_mclk);
    o_din[i] <= ~o_din[i];
  endtask
endmodule // drive_side_model

// ### sim/tb_drive_fault_manager.sv
// self-checking bench of the fault manager
`timescale 1ns/1ps
`include "fault_mgr_regs.svh"
module tb_drive_fault_manager;
  localparam int TICKS = 4;
  logic        mclk, reset, rd, wr, wait_req, drive_en, start_req;
  logic        disp_on, kp_owned, irq, f_raise, f_hard, f_pres, k_stop, k_esc, seen;
  logic [7:0]  addr, f_code, disp_num, c;
  logic [1:0]  din;
  logic [15:0] dly;
  logic [31:0] wdata, rdata, rv;
  int          err_count, n_tests;
  drive_fault_manager #(.TICK_CYCLES(TICKS)) i_drive_fault_manager (.i_mclk(mclk),
    .i_reset(reset), .i_fault_raise(f_raise), .i_fault_code(f_code), .i_fault_hard(f_hard),
    .i_fault_present(f_pres), .i_key_stop(k_stop), .i_key_esc(k_esc), .i_din(din),
    .i_avm_address(addr), .i_avm_read(rd), .i_avm_write(wr), .i_avm_writedata(wdata),
    .o_avm_readdata(rdata), .o_avm_waitrequest(wait_req), .o_drive_enable(drive_en),
    .o_start_request(start_req), .o_disp_fault_on(disp_on), .o_disp_fault_num(disp_num),
    .o_keypad_owned(kp_owned), .o_irq(irq));
  drive_side_model m (.i_mclk(mclk), .o_fault_raise(f_raise), .o_fault_code(f_code),
    .o_fault_hard(f_hard), .o_fault_present(f_pres), .o_key_stop(k_stop),
    .o_key_esc(k_esc), .o_din(din));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do @(posedge mclk); while (wait_req !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic wait_start(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge mclk);
      if (start_req === 1'b1) seen = 1'b1;
    end
  endtask
  // auto clear needs a delay, or one of the supply and heatsink codes
  function automatic logic exp_clear(input logic [15:0] t, input logic [7:0] k);
    return t != 16'h0000 || k == `FM_CODE_OVERVOLT || k == `FM_CODE_UNDERVOLT
      || k == `FM_CODE_HEATSINK;
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h38b1_140e));
    {reset, rd, wr, addr, wdata} = {1'b1, 42'h0};
    repeat (8) @(posedge mclk);
    chk({drive_en, kp_owned, irq, wait_req}, 4'h5);
    reset <= 1'b0;
    bus(0, `FM_OFS_TRIES, 0);
    chk(rv, {24'h0, `FM_TRIES_RST});
    bus(1, 8'hFC, 32'hFFFF_FFFF);
    bus(0, 8'hFC, 0);
    chk(rv, 0);
    bus(1, `FM_OFS_CTRL, 1);
    bus(1, `FM_OFS_IRQ_MASK, 32'h0000_0009);
    $display("test reset finished");
    c = 8'($urandom_range(1, 255));
    m.trip(c, 1'b1);
    settle();
    chk({drive_en, irq, disp_num}, {2'b01, c});
    bus(0, `FM_OFS_STATUS, 0);
    chk(rv[5:4], fault_mgr_pkg::CAT_HARD);
    bus(0, `FM_OFS_HIST0, 0);
    chk(rv[7:0], c);
    bus(1, `FM_OFS_CLEAR, 1);
    settle();
    chk(drive_en, 0);
    dly = '0;
    repeat (2200) @(posedge mclk) dly = dly | (disp_on === 1'b1 ? 16'h1 : 16'h2);
    chk(dly, 16'h3);
    m.press(1);
    settle();
    chk({kp_owned, disp_num, drive_en}, {1'b1, 8'h00, 1'b0});
    m.cure();
    bus(1, `FM_OFS_STOPSEL, 3);
    m.press(0);
    settle();
    chk(drive_en, 1);
    bus(1, `FM_OFS_IRQ_STAT, 1);
    bus(1, `FM_OFS_IRQ_MASK, 0);
    settle();
    chk(irq, 0);
    $display("test hard fault finished");
    m.trip(8'($urandom_range(1, 255)), 1'b0);
    m.cure();
    bus(1, `FM_OFS_STOPSEL, 4);
    m.press(0);
    settle();
    chk({drive_en, irq}, 0);
    bus(1, `FM_OFS_IRQ_MASK, 32'h0000_0009);
    settle();
    chk(irq, 1);
    bus(1, `FM_OFS_IRQ_STAT, 32'h0000_000F);
    bus(1, `FM_OFS_DIN2_FN, 7);
    m.toggle(1);
    settle();
    chk({drive_en, irq}, 2'b10);
    $display("test stop and input finished");
    for (int v = 0; v < 3; v++) begin
      c = 8'($urandom_range(1, 255));
      m.trip(c, 1'($urandom));
      m.cure();
      bus(1, `FM_OFS_CLEAR, v);
      settle();
      chk(drive_en, v != 0);
      bus(0, `FM_OFS_HIST0, 0);
      chk(rv[7:0], v == 2 ? 8'h00 : c);
      bus(1, `FM_OFS_CLEAR, 1);
    end
    $display("test clear request finished");
    bus(1, `FM_OFS_TRIES, 2);
    for (int k = 0; k < 3; k++) begin
      dly = k == 0 ? 16'($urandom_range(1, 3)) : 16'h0000;
      c = k == 0 ? 8'($urandom_range(1, 255)) : (k == 1 ? `FM_CODE_OVERVOLT : 8'h06);
      bus(1, `FM_OFS_DELAY, dly);
      m.trip(c, 1'b0);
      m.cure();
      wait_start(dly * TICKS + 60);
      chk(seen, dly != 0);
      chk(drive_en, exp_clear(dly, c));
      bus(1, `FM_OFS_CLEAR, 1);
    end
    $display("test auto restart finished");
    bus(1, `FM_OFS_DELAY, 1);
    // hard fault with retries armed and cause gone must stay latched
    m.trip(8'($urandom_range(1, 255)), 1'b1);
    m.cure();
    wait_start(60);
    chk({seen, drive_en}, 2'b00);
    bus(0, `FM_OFS_STATUS, 0);
    chk(rv[2:0], 3'h1);
    bus(1, `FM_OFS_CLEAR, 1);
    // drop the give-up bit left from the retry loop so the next check means something
    bus(1, `FM_OFS_IRQ_STAT, 32'h0000_000F);
    $display("test hard no retry finished");
    m.trip(8'($urandom_range(1, 255)), 1'b0);
    repeat (100) @(posedge mclk);
    bus(0, `FM_OFS_STATUS, 0);
    chk({rv[15:8], rv[2:0]}, {8'h02, 3'h4});
    bus(0, `FM_OFS_IRQ_STAT, 0);
    chk({irq, rv[3]}, 2'b11);
    m.cure();
    bus(1, `FM_OFS_CLEAR, 1);
    bus(1, `FM_OFS_IRQ_STAT, 32'h0000_000F);
    settle();
    chk({drive_en, irq}, 2'b10);
    $display("test give up finished");
    summarize();
  end
endmodule // tb_drive_fault_manager
